// file: hdl/p8g_top.sv
// Port-eight GPIO with LCD pin sharing, Avalon-MM register slave
// Contract
// RULE1 - Direction bit 1 makes the pin an output, 0 an input.
// RULE2 - Direction and latch act only on pins the select field leaves as GPIO.
// RULE3 - Reset clears the direction register, so all pins start as inputs.
// RULE4 - Direction register is write-only and always reads as all ones.
// RULE5 - Pin 7: port, glass line 32, or latch pulse when expansion is on.
// RULE6 - Pin 6: port, glass line 31, or shift pulse when expansion is on.
// RULE7 - Pin 5: port, glass line 30, or serial data when expansion is on.
// RULE8 - Pin 4: port, glass line 29, or AC drive when expansion is on.
// RULE9 - Pins 3 to 0: port at select zero, else glass line n+25.
// RULE10 - Pins float in reset and standby, hold in sleeps, run when active.
// RULE11 - Latch read gives stored bit for outputs, pin level for inputs.
// RULE12 - Reset clears the port latch register to all zeros.
// RULE13 - A GPIO output pin drives its latch bit.
// RULE14 - Glass and external LCD values come from the LCD controller, routed only.
`timescale 1ns/10ps
module p8g_top (
    input wire logic clk,
    input wire logic rstn,
    input wire p8g_pkg::p8g_av_req_t av_req,
    output logic [p8g_pkg::P8G_DW-1:0] av_readdata,
    output logic av_waitrequest,
    input wire p8g_pkg::p8g_mode_t op_mode,
    input wire p8g_pkg::p8g_lcd_t lcd_in,
    input wire logic [7:0] port_eight_pin_in,
    output logic [7:0] port_eight_pin_out,
    output logic [7:0] port_eight_pin_oe
);
    import p8g_pkg::*;

    // Reset release
    logic [1:0] rst_sync_q;
    logic rst_n;

    // Bus
    p8g_bus_state_t bus_state_q;
    p8g_bus_state_t bus_state_d;
    logic req_any;
    logic wr_lane0;
    logic do_write;

    // Registers
    logic [7:0] port8_direction_q;
    logic [7:0] port8_latch_q;
    logic [4:0] lcd_port_control_q;
    logic [3:0] segment_select_field;
    logic external_lcd_expand;

    // Pins
    logic [7:0] pin_level;
    logic [7:0] mux_val;
    logic [7:0] mux_oe;
    logic [7:0] gpio_mask;
    logic [31:0] read_value;

    function automatic logic hit(input logic [P8G_AW-1:0] addr,
                                 input logic [15:0] idx);
        hit = (addr == idx);
    endfunction

    // Stored bit for outputs, synchronised level for inputs
    function automatic logic [7:0] port_read(input logic [7:0] dir,
                                             input logic [7:0] stored,
                                             input logic [7:0] level);
        port_read = (dir & stored) | (~dir & level);
    endfunction

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    assign segment_select_field = lcd_port_control_q[P8G_SEL_LSB +: P8G_SEL_W];
    assign external_lcd_expand = lcd_port_control_q[P8G_EXPAND_BIT];

    p8g_sync #(
        .W(P8G_PINS)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(port_eight_pin_in),
        .sync_out(pin_level)
    );

    p8g_pin_mux u_mux (
        .direction(port8_direction_q),
        .latch(port8_latch_q),
        .segment_select_field(segment_select_field),
        .external_lcd_expand(external_lcd_expand),
        .lcd(lcd_in),
        .drive_val(mux_val),
        .drive_oe(mux_oe),
        .gpio_mask(gpio_mask)
    );

    // Bus handshake: request taken in idle, answered one cycle later
    assign req_any = av_req.read || av_req.write;
    assign wr_lane0 = av_req.write && av_req.byteenable[0];
    assign do_write = (bus_state_q == P8G_BUS_DONE) && wr_lane0;

    always_comb begin
        case (bus_state_q)
            P8G_BUS_IDLE: begin
                if (req_any) begin
                    bus_state_d = P8G_BUS_DONE;
                end else begin
                    bus_state_d = P8G_BUS_IDLE;
                end
            end
            P8G_BUS_DONE: begin
                bus_state_d = P8G_BUS_IDLE;
            end
            default: begin
                bus_state_d = P8G_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_q <= P8G_BUS_IDLE;
        end else begin
            bus_state_q <= bus_state_d;
        end
    end

    // Waitrequest low exactly in the answering cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            av_waitrequest <= 1'b1;
        end else begin
            av_waitrequest <= (bus_state_d != P8G_BUS_DONE);
        end
    end

    // Read mux
    always_comb begin
        read_value = P8G_UNMAPPED_READ;
        if (hit(av_req.address, P8G_IDX_LATCH)) begin
            read_value[7:0] = port_read(port8_direction_q, port8_latch_q,
                                        pin_level); // RULE11
        end else if (hit(av_req.address, P8G_IDX_DIRECTION)) begin
            read_value[7:0] = P8G_DIR_READ_VALUE; // RULE4
        end else if (hit(av_req.address, P8G_IDX_LCD_CTRL)) begin
            read_value[4:0] = lcd_port_control_q;
        end else if (hit(av_req.address, P8G_IDX_STATUS)) begin
            read_value[P8G_ST_GPIO_LSB +: 8] = gpio_mask;
            read_value[P8G_ST_OE_LSB +: 8] = port_eight_pin_oe;
            read_value[P8G_ST_MODE_LSB +: 3] = op_mode;
        end
    end

    // Read data captured when the request is taken, stands through the answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            av_readdata <= '0;
        end else if (bus_state_q == P8G_BUS_IDLE && av_req.read) begin
            av_readdata <= read_value;
        end
    end

    // Direction register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port8_direction_q <= P8G_RST_DIRECTION; // RULE3
        end else if (do_write && hit(av_req.address, P8G_IDX_DIRECTION)) begin
            port8_direction_q <= av_req.writedata[7:0]; // RULE1
        end
    end

    // Port latch register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port8_latch_q <= P8G_RST_LATCH; // RULE12
        end else if (do_write && hit(av_req.address, P8G_IDX_LATCH)) begin
            port8_latch_q <= av_req.writedata[7:0];
        end
    end

    // LCD port control: select field and expansion bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lcd_port_control_q <= P8G_RST_LCD_CTRL;
        end else if (do_write && hit(av_req.address, P8G_IDX_LCD_CTRL)) begin
            lcd_port_control_q <= av_req.writedata[4:0];
        end
    end

    // Pin drivers by operating mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_eight_pin_oe <= 8'h00; // RULE10
        end else begin
            case (op_mode)
                P8G_MODE_ACTIVE, P8G_MODE_SUBACTIVE: begin
                    port_eight_pin_oe <= mux_oe; // RULE2
                end
                P8G_MODE_SLEEP, P8G_MODE_SUBSLEEP, P8G_MODE_WATCH: begin
                    port_eight_pin_oe <= port_eight_pin_oe; // RULE10
                end
                P8G_MODE_STANDBY: begin
                    port_eight_pin_oe <= 8'h00; // RULE10
                end
                default: begin
                    port_eight_pin_oe <= 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_eight_pin_out <= 8'h00;
        end else begin
            case (op_mode)
                P8G_MODE_ACTIVE, P8G_MODE_SUBACTIVE: begin
                    port_eight_pin_out <= mux_val; // RULE13 RULE14
                end
                default: begin
                    port_eight_pin_out <= port_eight_pin_out; // RULE10
                end
            endcase
        end
    end
endmodule

// file: pkg/p8g_pkg.sv
// Constants and types shared by the port-eight GPIO and LCD pin-mux block
package p8g_pkg;

    // Port width and bus widths
    localparam int P8G_PINS = 8;
    localparam int P8G_AW = 16;
    localparam int P8G_DW = 32;
    localparam int P8G_BEW = 4;

    // Register indices, word addressed; byte address is four times the index
    localparam logic [15:0] P8G_IDX_LATCH = 16'hffdb;
    localparam logic [15:0] P8G_IDX_DIRECTION = 16'hffeb;
    localparam logic [15:0] P8G_IDX_LCD_CTRL = 16'hffc0;
    localparam logic [15:0] P8G_IDX_STATUS = 16'hffc1;

    // Reset values
    localparam logic [7:0] P8G_RST_LATCH = 8'h00;
    localparam logic [7:0] P8G_RST_DIRECTION = 8'h00;
    localparam logic [4:0] P8G_RST_LCD_CTRL = 5'h00;
    localparam logic [7:0] P8G_DIR_READ_VALUE = 8'hff;
    localparam logic [31:0] P8G_UNMAPPED_READ = 32'h0000_0000;

    // Field positions of lcd_port_control
    localparam int P8G_SEL_LSB = 0;
    localparam int P8G_SEL_W = 4;
    localparam int P8G_EXPAND_BIT = 4;
    localparam logic [3:0] P8G_SEL_GPIO = 4'h0;

    // Field positions of the status register
    localparam int P8G_ST_GPIO_LSB = 0;
    localparam int P8G_ST_OE_LSB = 8;
    localparam int P8G_ST_MODE_LSB = 16;

    // Pins carrying the external LCD interface when expansion is on
    localparam int P8G_PIN_LATCH = 7;
    localparam int P8G_PIN_SHIFT = 6;
    localparam int P8G_PIN_SERIAL = 5;
    localparam int P8G_PIN_AC = 4;
    localparam int P8G_EXT_LSB = 4;

    // Operating modes of the chip
    typedef enum logic [2:0] {
        P8G_MODE_ACTIVE = 3'b000,
        P8G_MODE_SUBACTIVE = 3'b001,
        P8G_MODE_SLEEP = 3'b010,
        P8G_MODE_SUBSLEEP = 3'b011,
        P8G_MODE_WATCH = 3'b100,
        P8G_MODE_STANDBY = 3'b101
    } p8g_mode_t;

    // Bus handshake states
    typedef enum logic [0:0] {
        P8G_BUS_IDLE = 1'b0,
        P8G_BUS_DONE = 1'b1
    } p8g_bus_state_t;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [P8G_AW-1:0] address;
        logic [P8G_DW-1:0] writedata;
        logic [P8G_BEW-1:0] byteenable;
    } p8g_av_req_t;

    // Signals from the LCD controller, routed only
    typedef struct packed {
        logic [7:0] glass_line;
        logic lcd_latch_pulse;
        logic lcd_shift_pulse;
        logic serial_data;
        logic ac_drive;
    } p8g_lcd_t;

endpackage

// file: hdl/p8g_sync.sv
// Three-stage input synchroniser with agreement filter for the port pins
`timescale 1ns/10ps
module p8g_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_out <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// file: hdl/p8g_pin_mux.sv
// Per-pin function select: port pin, glass line or external LCD signal
`timescale 1ns/10ps
module p8g_pin_mux (
    input wire logic [7:0] direction,
    input wire logic [7:0] latch,
    input wire logic [3:0] segment_select_field,
    input wire logic external_lcd_expand,
    input wire p8g_pkg::p8g_lcd_t lcd,
    output logic [7:0] drive_val,
    output logic [7:0] drive_oe,
    output logic [7:0] gpio_mask
);
    import p8g_pkg::*;

    logic sel_zero;
    logic [7:0] ext_val;

    assign sel_zero = (segment_select_field == P8G_SEL_GPIO);

    always_comb begin
        // Indexed by pin number so no lane index can go negative
        ext_val = 8'h00;
        ext_val[P8G_PIN_LATCH] = lcd.lcd_latch_pulse;
        ext_val[P8G_PIN_SHIFT] = lcd.lcd_shift_pulse;
        ext_val[P8G_PIN_SERIAL] = lcd.serial_data;
        ext_val[P8G_PIN_AC] = lcd.ac_drive;
        for (int i = 0; i < 8; i++) begin
            // Port pin only when select is zero and, on upper pins, expansion off
            if (sel_zero && (i < P8G_EXT_LSB || !external_lcd_expand)) begin
                gpio_mask[i] = 1'b1; // RULE2
                drive_oe[i] = direction[i]; // RULE1 RULE9
                drive_val[i] = latch[i]; // RULE13
            end else if (sel_zero) begin
                gpio_mask[i] = 1'b0;
                drive_oe[i] = 1'b1; // RULE5 RULE6 RULE7 RULE8
                drive_val[i] = ext_val[i]; // RULE14
            end else begin
                gpio_mask[i] = 1'b0;
                drive_oe[i] = 1'b1; // RULE5 RULE6 RULE7 RULE8 RULE9
                drive_val[i] = lcd.glass_line[i]; // RULE14
            end
        end
    end
endmodule

// file: tb/p8g_top_props.sv
// Checker for the port-eight pin mux and its register bus
`timescale 1ns/10ps
module p8g_top_props (
    input wire logic clk,
    input wire logic rstn,
    input wire p8g_pkg::p8g_av_req_t av_req,
    input wire logic [p8g_pkg::P8G_DW-1:0] av_readdata,
    input wire logic av_waitrequest,
    input wire p8g_pkg::p8g_mode_t op_mode,
    input wire p8g_pkg::p8g_lcd_t lcd_in,
    input wire logic [7:0] port_eight_pin_in,
    input wire logic [7:0] port_eight_pin_out,
    input wire logic [7:0] port_eight_pin_oe
);
    import p8g_pkg::*;
    logic [7:0] dir_q;
    logic [7:0] lat_q;
    logic [3:0] sel_q;
    logic exp_q;
    logic [1:0] rc_q;
    wire acc = !av_waitrequest && av_req.write && av_req.byteenable[0];
    wire act = op_mode == P8G_MODE_ACTIVE || op_mode == P8G_MODE_SUBACTIVE;
    wire hold = op_mode inside {P8G_MODE_SLEEP, P8G_MODE_SUBSLEEP, P8G_MODE_WATCH};
    wire rdy = rc_q == 2'd3;
    wire rd_ans = !av_waitrequest && av_req.read;
    // Internal reset outlasts rstn by two edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rc_q <= 2'd0;
        else if (!rdy) rc_q <= rc_q + 2'd1;
    end
    // Mirror of register writes as seen on the bus
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dir_q <= 8'h00;
            lat_q <= 8'h00;
            {exp_q, sel_q} <= 5'h00;
        end else if (acc) begin
            if (av_req.address == P8G_IDX_DIRECTION) dir_q <= av_req.writedata[7:0];
            if (av_req.address == P8G_IDX_LATCH) lat_q <= av_req.writedata[7:0];
            if (av_req.address == P8G_IDX_LCD_CTRL) {exp_q, sel_q} <= av_req.writedata[4:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_wait_pulse: assert property (!av_waitrequest |=> av_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_reset_float: assert property (!rdy |-> port_eight_pin_oe == 8'h00)
        else $error("pins driven during reset");
    chk_dir_ones: assert property (rd_ans && av_req.address == P8G_IDX_DIRECTION
        |-> av_readdata == 32'h0000_00ff) else $error("direction read not all ones");
    chk_latch_stored: assert property (rd_ans && av_req.address == P8G_IDX_LATCH
        |-> (av_readdata[7:0] & dir_q) == (lat_q & dir_q)) else $error("latch read wrong");
    chk_gpio_drive: assert property (rdy && act && sel_q == 4'h0 && !exp_q
        |=> port_eight_pin_oe == $past(dir_q)
        && (port_eight_pin_out & port_eight_pin_oe) == ($past(lat_q) & $past(dir_q)))
        else $error("port pin drive wrong");
    chk_ext_route: assert property (rdy && act && sel_q == 4'h0 && exp_q
        |=> port_eight_pin_oe[7:4] == 4'hf && port_eight_pin_out[7:4] == $past(lcd_in[3:0]))
        else $error("external lcd signals wrong");
    chk_low_gpio: assert property (rdy && act && sel_q == 4'h0 && exp_q
        |=> {4'h0, port_eight_pin_oe[3:0]} == ($past(dir_q) & 8'h0f))
        else $error("low pins not port pins");
    chk_glass_route: assert property (rdy && act && sel_q != 4'h0
        |=> port_eight_pin_oe == 8'hff && port_eight_pin_out == $past(lcd_in.glass_line))
        else $error("glass lines wrong");
    chk_standby_float: assert property (op_mode == P8G_MODE_STANDBY
        |=> port_eight_pin_oe == 8'h00) else $error("pins driven in standby");
    chk_sleep_hold: assert property (rdy && hold
        |=> $stable(port_eight_pin_out) && $stable(port_eight_pin_oe))
        else $error("pins changed while held");
    cover property (rdy && act && exp_q && sel_q == 4'h0);
    cover property (rdy && act && sel_q != 4'h0);
    cover property (rdy && hold);
endmodule
bind p8g_top p8g_top_props u_p8g_top_props (.clk(clk), .rstn(rstn), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .op_mode(op_mode),
    .lcd_in(lcd_in), .port_eight_pin_in(port_eight_pin_in),
    .port_eight_pin_out(port_eight_pin_out), .port_eight_pin_oe(port_eight_pin_oe));

// file: tb/p8g_far.sv
// Board side of the port: pin levels fed back to the block
`timescale 1ns/10ps
module p8g_far (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    // Driven pins read back their drive, others the board level
    assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

// file: tb/tb_p8g_top.sv
// Self-checking bench for the port-eight pin mux
`timescale 1ns/10ps
module tb_p8g_top;
    import p8g_pkg::*;
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] lat;
        logic [7:0] ctl;
        p8g_lcd_t lcd;
        logic [7:0] oe;
        logic [7:0] out;
    } p8g_row_t;
    logic clk;
    logic rstn;
    p8g_av_req_t req;
    logic [31:0] rdata;
    logic waitreq;
    p8g_mode_t mode;
    p8g_lcd_t lcd;
    logic [7:0] ext;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [31:0] q;
    int errors;
    int n_compared;
    p8g_row_t rows [8];
    p8g_mode_t holds [3];
    p8g_top u_p8g_top (.clk(clk), .rstn(rstn), .av_req(req), .av_readdata(rdata),
        .av_waitrequest(waitreq), .op_mode(mode), .lcd_in(lcd), .port_eight_pin_in(pin_in),
        .port_eight_pin_out(pin_out), .port_eight_pin_oe(pin_oe));
    p8g_far u_p8g_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] r);
        @(posedge clk);
        req <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        r = rdata;
        req <= '0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, {24'h0, d}, 4'hf, r);
    endtask
    task automatic rd(input logic [15:0] a);
        bus(1'b0, a, 32'h0, 4'h0, q);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic do_reset;
        rstn <= 1'b0;
        wait_n(2);
        rstn <= 1'b1;
        // Pin synchroniser needs four edges after the internal reset ends
        wait_n(6);
        check(pin_oe, 32'h0);
        rd(P8G_IDX_LATCH);
        check(q, {24'h0, ext});
        rd(P8G_IDX_DIRECTION);
        check(q, 32'hff);
        wr(P8G_IDX_DIRECTION, 8'hff);
        rd(P8G_IDX_LATCH);
        check(q, 32'h0);
    endtask
    task complete_run;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        complete_run;
    end
    initial begin
        rstn = 1'b0;
        req = '0;
        mode = P8G_MODE_ACTIVE;
        lcd = '0;
        ext = 8'h96;
        errors = 0;
        n_compared = 0;
        holds = '{P8G_MODE_SLEEP, P8G_MODE_SUBSLEEP, P8G_MODE_WATCH};
        rows[0] = '{8'hff, 8'ha5, 8'h00, 12'h000, 8'hff, 8'ha5};
        rows[1] = '{8'h0f, 8'h3c, 8'h00, 12'hff0, 8'h0f, 8'h0c};
        rows[2] = '{8'h00, 8'h00, 8'h10, 12'h00a, 8'hf0, 8'ha0};
        rows[3] = '{8'h0f, 8'h05, 8'h10, 12'h005, 8'hff, 8'h55};
        rows[4] = '{8'hff, 8'h00, 8'h02, 12'h5a0, 8'hff, 8'h5a};
        rows[5] = '{8'h00, 8'hff, 8'h04, 12'hc3f, 8'hff, 8'hc3};
        rows[6] = '{8'hff, 8'h00, 8'h08, 12'h3c0, 8'hff, 8'h3c};
        rows[7] = '{8'h0f, 8'h00, 8'h1f, 12'h81f, 8'hff, 8'h81};
        do_reset;
        foreach (rows[i]) begin
            wr(P8G_IDX_DIRECTION, rows[i].dir);
            wr(P8G_IDX_LATCH, rows[i].lat);
            wr(P8G_IDX_LCD_CTRL, rows[i].ctl);
            lcd <= rows[i].lcd;
            wait_n(3);
            check(pin_oe, rows[i].oe);
            check(pin_out & pin_oe, rows[i].out);
        end
        wr(P8G_IDX_LCD_CTRL, 8'h00);
        wr(P8G_IDX_DIRECTION, 8'h0f);
        wr(P8G_IDX_LATCH, 8'h0a);
        wait_n(6);
        rd(P8G_IDX_LATCH);
        check(q, {24'h0, ext[7:4], 4'ha});
        rd(P8G_IDX_STATUS);
        check(q, 32'h0000_0fff);
        bus(1'b1, P8G_IDX_LATCH, 32'hff, 4'h0, q);
        wr(16'h0001, 8'h55);
        rd(16'h0001);
        check(q, 32'h0);
        rd(P8G_IDX_LATCH);
        check(q, {24'h0, ext[7:4], 4'ha});
        foreach (holds[i]) begin
            wr(P8G_IDX_DIRECTION, 8'hff);
            wr(P8G_IDX_LATCH, 8'h00);
            wait_n(2);
            mode <= holds[i];
            wait_n(2);
            wr(P8G_IDX_LATCH, 8'h5a);
            wr(P8G_IDX_DIRECTION, 8'h00);
            wait_n(3);
            check({pin_oe, pin_out}, 16'hff00);
            mode <= P8G_MODE_ACTIVE;
            wait_n(3);
            check(pin_oe, 32'h0);
        end
        mode <= P8G_MODE_SUBACTIVE;
        wr(P8G_IDX_DIRECTION, 8'hff);
        wr(P8G_IDX_LATCH, 8'h3c);
        wait_n(3);
        check(pin_out, 32'h3c);
        mode <= P8G_MODE_STANDBY;
        wait_n(3);
        check(pin_oe, 32'h0);
        mode <= P8G_MODE_ACTIVE;
        wait_n(3);
        check(pin_oe, 32'hff);
        mode <= p8g_mode_t'(3'b111);
        wait_n(3);
        check(pin_oe, 32'h0);
        mode <= P8G_MODE_ACTIVE;
        do_reset;
        complete_run;
    end
endmodule
